// ==== common/sbabt_regs.svh ====
/*
  Register offsets, field positions, reset values and timing counts for the
  serial bus arbiter bit timer.
  Assumes inclusion by bare name from a package or module.
*/
`ifndef SBABT_REGS_SVH
`define SBABT_REGS_SVH

// register offsets on the plain register port
`define SBABT_ADDR_W          1
`define SBABT_OFF_CONTROL     1'h0
`define SBABT_OFF_COUNT_LOW   1'h1

// control register field positions
`define SBABT_BIT_COUNT_MSB   0
`define SBABT_BIT_OVERFLOW    1
`define SBABT_BIT_RUNNING     2
`define SBABT_BIT_DONE        3
`define SBABT_BIT_CLK_SEL     4
`define SBABT_BIT_LOST        5
`define SBABT_BIT_MODE_LOW    6
`define SBABT_BIT_MODE_HIGH   7

// reset values
`define SBABT_RST_MODE        2'h0
`define SBABT_RST_COUNT       9'h000

// arbitration sample points
`define SBABT_SAMPLE_BUSCLK   9'h038
`define SBABT_SAMPLE_PRESC    9'h008

// counter advances once every four source ticks
`define SBABT_DIV_RATIO       4
`define SBABT_DIV_W           2

`endif

// ==== common/sbabt_pkg.sv ====
/*
  Types for the serial bus arbiter bit timer.
  Assumes the constants header sits beside it.
*/
package sbabt_pkg;
  `include "sbabt_regs.svh"

  typedef enum logic [1:0] {
    SBABT_MODE_IDLE    = 2'h0,
    SBABT_MODE_MEASURE = 2'h1,
    SBABT_MODE_ARB     = 2'h2,
    SBABT_MODE_RSVD    = 2'h3
  } sbabt_mode_e;

  typedef enum logic [1:0] {
    SBABT_ST_WAIT,
    SBABT_ST_RUN,
    SBABT_ST_STOP
  } sbabt_state_e;

  typedef logic [8:0] sbabt_count_t;
endpackage

// ==== design/sbabt_top.sv ====
/*
  Serial bus arbiter bit timer: 9-bit counter with overflow, bit-time
  measurement and single-wire bus arbitration, behind a plain register port.
  Assumes the receive line, transmit output and prescaler tick are
  synchronous to ref_clk; the prescaler tick is a one-cycle pulse.
*/
`timescale 1ns/1ps
`include "sbabt_regs.svh"

// Overview of operation
// - nine-bit up-counter with sticky overflow flag
// - mode field: idle, measure, arbitrate, reserved
// - reset clears mode, clock select, flags, counter
// - lost flag cleared by writing zero high-bit
// - counter advances at source divided by four
// - prescaler source chosen outside this unit
// - done flag set on finish, control write clears
// - running flag mirrors counter counting
// - overflow flag set on wrap, control write clears
// - msb in control, low byte separate, control writes clear
// - idle mode holds counter cleared continuously
// - bus-clock measure: falling edge to falling edge
// - bus-clock measure: done at second falling edge
// - prescaler measure starts on low level
// - prescaler measure stops at rising edge
// - arbitration restarts counter on transmit rise, except when stopped with lost flag set
// - sample receive at 38h or 08h, low loses
// - lost flag forces transmit pin high
// - early transmit low resets, waits next rise
module sbabt_top
  import sbabt_pkg::*;
(
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  input  wire logic [`SBABT_ADDR_W-1:0]  regAddr,
  input  wire logic [7:0]                regWdata,
  input  wire logic                      regWrite,
  input  wire logic                      regRead,
  output logic      [7:0]                regRdata,
  input  wire logic                      prescTick,
  input  wire logic                      rxLine,
  input  wire logic                      txInternal,
  output logic                           txPin
);

  ////////////////////////////////////////////////////////////////////////
  // reset release

  logic rstMeta_r;
  logic rstSync_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive synchroniser and edge detection

  logic rxMeta_r;
  logic rxSync_r;
  logic rxPrev_r;
  logic txPrev_r;

  // both stages reset to the idle high level, so that no false falling
  // edge follows the release of reset
  always_ff @(posedge ref_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      rxMeta_r <= 1'b1;
      rxSync_r <= 1'b1;
    end else begin
      rxMeta_r <= rxLine;
      rxSync_r <= rxMeta_r;
    end
  end

  always_ff @(posedge ref_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      rxPrev_r <= 1'b1;
    end else begin
      rxPrev_r <= rxSync_r;
    end
  end

  // the transmit output is already in this domain, so one stage is
  // enough to find its rising edge
  always_ff @(posedge ref_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      txPrev_r <= 1'b1;
    end else begin
      txPrev_r <= txInternal;
    end
  end

  function automatic logic risingEdge(input logic prev,
                                      input logic now);
    risingEdge = ~prev & now;
  endfunction

  wire rxFall = rxPrev_r & ~rxSync_r;
  wire rxRise = risingEdge(rxPrev_r, rxSync_r);
  wire txRise = risingEdge(txPrev_r, txInternal);
  wire txLow  = ~txInternal;

  ////////////////////////////////////////////////////////////////////////
  // register decode

  function automatic logic addrHit(input logic [`SBABT_ADDR_W-1:0] a,
                                   input logic [`SBABT_ADDR_W-1:0] off);
    addrHit = (a == off);
  endfunction

  wire ctrlWrite = regWrite & addrHit(regAddr, `SBABT_OFF_CONTROL);
  wire ctrlRead  = regRead & addrHit(regAddr, `SBABT_OFF_CONTROL);
  wire lowRead   = regRead & addrHit(regAddr, `SBABT_OFF_COUNT_LOW);

  wire [1:0] wrMode   = {regWdata[`SBABT_BIT_MODE_HIGH],
                         regWdata[`SBABT_BIT_MODE_LOW]};
  wire       wrClkSel = regWdata[`SBABT_BIT_CLK_SEL];

  ////////////////////////////////////////////////////////////////////////
  // control state

  sbabt_mode_e  mode_r;
  logic         clkSel_r;
  logic         lost_r;
  logic         done_r;
  logic         ovfl_r;
  sbabt_count_t count_r;
  sbabt_state_e state_r;
  logic [`SBABT_DIV_W-1:0] div_r;

  // software must not write the reserved mode; it is treated as idle
  wire modeIdle    = (mode_r == SBABT_MODE_IDLE) ||
                     (mode_r == SBABT_MODE_RSVD);
  wire modeMeasure = (mode_r == SBABT_MODE_MEASURE);
  wire modeArb     = (mode_r == SBABT_MODE_ARB);

  // source tick: bus clock or external prescaler output, whose own
  // source selection lives in the configuration logic outside
  wire srcTick = clkSel_r ? prescTick : 1'b1;
  wire divWrap = srcTick &&
                 (div_r == `SBABT_DIV_W'(`SBABT_DIV_RATIO - 1));
  wire running = (state_r == SBABT_ST_RUN);
  wire advance = running & divWrap;

  wire [9:0] countSum = {1'b0, count_r} + 10'h001;
  wire       countCarry = advance & countSum[9];

  wire [8:0] samplePoint = clkSel_r ? `SBABT_SAMPLE_PRESC
                                    : `SBABT_SAMPLE_BUSCLK;
  wire sampleNow = modeArb & running & advance &
                   (countSum[8:0] == samplePoint);
  wire lostSet   = sampleNow & ~rxSync_r;

  // start and stop conditions in each measurement flavour
  wire measStop = modeMeasure & running &
                  (clkSel_r ? rxRise : rxFall);
  wire measStart = modeMeasure & (state_r == SBABT_ST_WAIT) &
                   (clkSel_r ? ~rxSync_r : rxFall);

  ////////////////////////////////////////////////////////////////////////
  // counter state machine

  sbabt_state_e state_nxt;
  sbabt_count_t count_nxt;

  always_comb begin
    state_nxt = state_r;
    count_nxt = advance ? countSum[8:0] : count_r;
    case (state_r)
      SBABT_ST_WAIT: begin
        if (measStart) begin
          state_nxt = SBABT_ST_RUN;
        end else if (modeArb & txRise) begin
          state_nxt = SBABT_ST_RUN;
          count_nxt = `SBABT_RST_COUNT;
        end
      end
      SBABT_ST_RUN: begin
        if (measStop) begin
          state_nxt = SBABT_ST_STOP;
          count_nxt = count_r;
        end else if (modeArb & txRise) begin
          count_nxt = `SBABT_RST_COUNT;
        end else if (modeArb & txLow) begin
          state_nxt = SBABT_ST_WAIT;
          count_nxt = `SBABT_RST_COUNT;
        end else if (modeArb & sampleNow) begin
          state_nxt = SBABT_ST_STOP;
        end
      end
      SBABT_ST_STOP: begin
        if (modeArb & txRise & ~lost_r) begin
          state_nxt = SBABT_ST_RUN;
          count_nxt = `SBABT_RST_COUNT;
        end
      end
      default: begin
        state_nxt = SBABT_ST_WAIT;
      end
    endcase
    if (modeIdle) begin
      state_nxt = SBABT_ST_WAIT;
      count_nxt = `SBABT_RST_COUNT;
    end
    if (ctrlWrite) begin
      state_nxt = SBABT_ST_WAIT;
      count_nxt = `SBABT_RST_COUNT;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // divider and counter registers

  // the divider is held clear while the counter is not running, so the first
  // step after a start from wait or stop always takes four full source ticks
  wire divClear = modeIdle | ctrlWrite | ~running;
  wire [`SBABT_DIV_W-1:0] div_nxt = divClear ? `SBABT_DIV_W'(0) :
                                    srcTick  ? div_r + `SBABT_DIV_W'(1) :
                                               div_r;

  always_ff @(posedge ref_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      div_r <= '0;
    end else begin
      div_r <= div_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      state_r <= SBABT_ST_WAIT;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      count_r <= `SBABT_RST_COUNT;
    end else begin
      count_r <= count_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode, clock select and flags

  always_ff @(posedge ref_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      mode_r <= sbabt_mode_e'(`SBABT_RST_MODE);
    end else if (ctrlWrite) begin
      mode_r <= sbabt_mode_e'(wrMode);
    end
  end

  always_ff @(posedge ref_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      clkSel_r <= 1'b0;
    end else if (ctrlWrite) begin
      clkSel_r <= wrClkSel;
    end
  end

  // flags set by hardware win over a clear in the same cycle
  wire lostClear = ctrlWrite & ~wrMode[1];
  wire doneClear = ctrlWrite;
  wire ovflClear = ctrlWrite;

  always_ff @(posedge ref_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      lost_r <= 1'b0;
    end else if (lostSet) begin
      lost_r <= 1'b1;
    end else if (lostClear) begin
      lost_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      done_r <= 1'b0;
    end else if (measStop) begin
      done_r <= 1'b1;
    end else if (doneClear) begin
      done_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      ovfl_r <= 1'b0;
    end else if (countCarry) begin
      ovfl_r <= 1'b1;
    end else if (ovflClear) begin
      ovfl_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data and transmit pin

  wire [7:0] ctrlView = {mode_r[1], mode_r[0], lost_r, clkSel_r,
                         done_r, running, ovfl_r, count_r[8]};
  wire [7:0] rdNext = ctrlRead ? ctrlView :
                      lowRead  ? count_r[7:0] : 8'h00;

  wire txPinNxt = txInternal | lost_r;

  always_ff @(posedge ref_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      regRdata <= 8'h00;
    end else begin
      regRdata <= rdNext;
    end
  end

  // the pin idles high during reset so the bus is never held dominant
  always_ff @(posedge ref_clk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      txPin <= 1'b1;
    end else begin
      txPin <= txPinNxt;
    end
  end

endmodule

// ==== dv/sbabt_chk.sv ====
/* port checker for the arbiter bit timer, bound to its top module.
   assumes one clock and the plain register port contract. */
`timescale 1ns/1ps
module sbabt_chk
  import sbabt_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic [0:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regRdata,
  input wire logic       prescTick,
  input wire logic       rxLine,
  input wire logic       txInternal,
  input wire logic       txPin
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic       ctlWr;
  logic       ctlRd;
  logic [2:0] cfgR;
  assign ctlWr = regWrite && !regAddr;
  assign ctlRd = regRead && !regAddr;
  // shadow of mode and clock select, so readback can be predicted
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfgR <= 3'h0;
    end else if (ctlWr) begin
      cfgR <= {regWdata[7:6], regWdata[4]};
    end
  end
////////////////////////////////////////
  a_rdata_idle: assert property (
    !$past(regRead) |-> regRdata == 8'h00) else $error("rdata not idle");
  a_ctrl_back: assert property (
    $past(ctlRd) |-> {regRdata[7:6], regRdata[4]} == $past(cfgR))
    else $error("control readback wrong");
  a_wr_clr: assert property (
    ctlWr ##2 ctlRd |=> regRdata[3] == 1'b0 && regRdata[1:0] == 2'h0)
    else $error("flags not cleared");
  a_wr_clr_low: assert property (
    ctlWr ##4 (regRead && regAddr) |=> regRdata[7:1] == 7'h00)
    else $error("count not cleared");
  a_idle_zero: assert property (
    $past(regRead && regAddr && cfgR[2:1] == 2'h0) |-> regRdata == 8'h00)
    else $error("idle count not zero");
  a_tx_high: assert property (
    txInternal |=> txPin) else $error("tx pin not high");
  a_lost_tx: assert property (
    $past(ctlRd) && regRdata[5] |-> txPin) else $error("lost, tx low");
  a_lost_clr: assert property (
    ctlWr && !regWdata[7] |-> ##2 txPin == $past(txInternal))
    else $error("lost not cleared");
endmodule
bind sbabt_top sbabt_chk i_sbabt_chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
  .regRead(regRead), .regRdata(regRdata), .prescTick(prescTick),
  .rxLine(rxLine), .txInternal(txInternal), .txPin(txPin));

// ==== dv/sbabt_bus_node.sv ====
/* another node on the shared single-wire bus.
   assumes the bench drives claim to make this node dominant. */
`timescale 1ns/1ps
module sbabt_bus_node (
  input  wire logic ref_clk,
  input  wire logic txPin,
  input  wire logic claim,
  output logic      rxLine
);
  initial rxLine = 1'b1;
  // wired-and: a dominant low wins; one cycle of wire delay
  always @(posedge ref_clk) rxLine <= txPin & ~claim;
endmodule

// ==== dv/testbench.sv ====
/* self-checking bench for the arbiter bit timer.
   assumes the bus node model drives the receive line. */
`timescale 1ns/1ps
module testbench;
  logic       ref_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       regAddr = 1'b0;
  logic [7:0] regWdata = 8'h00;
  logic       regWrite = 1'b0;
  logic       regRead = 1'b0;
  logic [7:0] regRdata;
  logic       prescTick = 1'b0;
  logic       rxLine;
  logic       txInternal = 1'b1;
  logic       txPin;
  logic       claim = 1'b0;
  logic [7:0] c;
  logic [7:0] d;
  int         k;
  int         fails = 0;
  int         samples_checked = 0;
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) prescTick <= ~prescTick;
  sbabt_top i_sbabt_top (.ref_clk(ref_clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .prescTick(prescTick),
    .rxLine(rxLine), .txInternal(txInternal), .txPin(txPin));
  sbabt_bus_node i_sbabt_bus_node (.ref_clk(ref_clk), .txPin(txPin),
    .claim(claim), .rxLine(rxLine));
////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic a, input logic [7:0] v);
    @(posedge ref_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= v;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic a, output logic [7:0] v);
    @(posedge ref_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 v = regRdata;
  endtask
  task automatic dip;
    @(posedge ref_clk) claim <= 1'b1;
    cyc(2);
    claim <= 1'b0;
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] expCtrl(input logic [7:0] v);
    return {v[7:6], 1'b0, v[4], 4'h0};
  endfunction
  // divider phase is unknown, so one count either way is accepted
  function automatic logic near(input logic [8:0] got, input int n);
    logic [8:0] diff;
    diff = got - 9'(n) + 9'h001;
    return diff <= 9'h002;
  endfunction
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    complete_run;
  end
  initial begin
    void'($urandom(10802));
    cyc(10);
    rst_n <= 1'b1;
    cyc(4);
    rd(1'b0, c);
    chk({1'b0, c}, 9'h000);
    rd(1'b1, c);
    chk({1'b0, c}, 9'h000);
    for (int i = 0; i < 24; i++) begin
      d = 8'($urandom);
      d[7:6] = 2'($urandom % 3);
      wr(1'b1, 8'($urandom));
      wr(1'b0, d);
      rd(1'b0, c);
      chk({1'b0, c}, {1'b0, expCtrl(d)});
      rd(1'b1, c);
      chk({1'b0, c}, 9'h000);
    end
    $display("test registers done");
    for (int i = 0; i < 3; i++) begin
      k = (i == 2) ? 700 : 20 + $urandom % 460;
      wr(1'b0, 8'h40);
      dip();
      cyc(4 * k - 3);
      dip();
      cyc(12);
      rd(1'b0, c);
      rd(1'b1, d);
      chk({8'h00, near({c[0], d}, k)}, 9'h001);
      chk({6'h00, c[3:1]}, {6'h00, 2'b10, k > 511});
    end
    $display("test bit time done");
    @(posedge ref_clk) claim <= 1'b1;
    cyc(4);
    wr(1'b0, 8'h50);
    cyc(16);
    rd(1'b0, c);
    chk({8'h00, c[2]}, 9'h001);
    cyc(222);
    claim <= 1'b0;
    cyc(12);
    rd(1'b0, c);
    rd(1'b1, d);
    chk({8'h00, near({c[0], d}, 30)}, 9'h001);
    chk({6'h00, c[3:1]}, 9'h004);
    $display("test break done");
    for (int j = 0; j < 4; j++) begin
      wr(1'b0, {3'b100, j[0], 4'h0});
      txInternal <= 1'b0;
      claim <= j[1];
      cyc(4);
      txInternal <= 1'b1;
      cyc(j[0] ? 50 : 210);
      rd(1'b0, c);
      chk({8'h00, c[5]}, 9'h000);
      cyc(40);
      rd(1'b0, c);
      chk({8'h00, c[5]}, {8'h00, j[1]});
      @(posedge ref_clk) txInternal <= 1'b0;
      cyc(3);
      #1 chk({8'h00, txPin}, {8'h00, j[1]});
      wr(1'b0, 8'h00);
      cyc(3);
      #1 chk({8'h00, txPin}, 9'h000);
      claim <= 1'b0;
      txInternal <= 1'b1;
    end
    $display("test arbitration done");
    // transmit drops low before the sample point: counter resets and waits
    wr(1'b0, 8'h80);
    @(posedge ref_clk) txInternal <= 1'b0;
    cyc(4);
    txInternal <= 1'b1;
    cyc(100);
    txInternal <= 1'b0;
    cyc(2);
    rd(1'b0, c);
    rd(1'b1, d);
    chk({c[0], d}, 9'h000);
    chk({8'h00, c[2]}, 9'h000);
    @(posedge ref_clk) txInternal <= 1'b1;
    cyc(12);
    rd(1'b0, c);
    chk({8'h00, c[2]}, 9'h001);
    $display("test early transmit done");
    complete_run;
  end
endmodule
